// [hw/dma_defs.vh]
// Register offsets, field positions, codes and sizes of the bus-master DMA engine
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH
`define OFF_CMD         8'h40
`define OFF_STC         8'h44
`define OFF_SPA         8'h48
`define OFF_WBC         8'h4c
`define OFF_WAC         8'h50
`define OFF_STATUS      8'h54
`define OFF_DLB         8'h58
`define OFF_WDC         8'h5c
`define ROUTE_BIT       4
`define CMD_DIR         7
`define CMD_XIRQ        6
`define CMD_PIRQ        5
`define CMD_MAP         4
`define CODE_IDLE       2'h0
`define CODE_FLUSH      2'h1
`define CODE_ABORT      2'h2
`define CODE_START      2'h3
`define ST_RUN          0
`define ST_ABORTED      2
`define ST_DONE         3
`define ST_SCSI_IRQ     4
`define ST_FLUSHED      5
`define CMD_RESET       8'h00
`define WBC_RESET       24'h000000
`define WAC_RESET       32'hffffffff
`define FIFO_WORDS      5'd24
`define BURST_WORDS     5'd16
`define PAGE_WORDS      11'd1024
`endif

// [hw/dma_word_fifo.v]
// 24-doubleword flip-flop FIFO with head and next-head views
`timescale 1ns/1ps
`include "dma_defs.vh"
module dma_word_fifo (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // Control
   input  wire        clear_in,
   input  wire        push_in,
   input  wire [31:0] push_data_in,
   input  wire        pop_in,
   // State
   output wire [31:0] head_out,
   output wire [31:0] next_out,
   output wire [4:0]  count_out,
   output wire        full_out,
   output wire        empty_out
);
   reg  [31:0] mem_q [0:23];
   reg  [4:0]  wr_q;
   reg  [4:0]  rd_q;
   reg  [4:0]  cnt_q;
   wire        do_push = push_in & ~full_out;
   wire        do_pop  = pop_in & ~empty_out;
   wire [4:0]  rd_nx   = (rd_q == `FIFO_WORDS - 5'd1) ? 5'd0 : rd_q + 5'd1;

   assign head_out  = mem_q[rd_q];
   assign next_out  = mem_q[rd_nx];
   assign count_out = cnt_q;
   assign full_out  = (cnt_q == `FIFO_WORDS);
   assign empty_out = (cnt_q == 5'd0);

   genvar i;
   generate
      for (i = 0; i < 24; i = i + 1) begin : slot
         localparam [4:0] SLOT = i;
         always @(posedge clk_in) begin
            if (do_push && wr_q == SLOT) begin
               mem_q[i] <= push_data_in;
            end
         end
      end
   endgenerate

   always @(posedge clk_in) begin
      if (rst_in || clear_in) begin
         wr_q  <= 5'd0;
         rd_q  <= 5'd0;
         cnt_q <= 5'd0;
      end else begin
         if (do_push) begin
            wr_q <= (wr_q == `FIFO_WORDS - 5'd1) ? 5'd0 : wr_q + 5'd1;
         end
         if (do_pop) begin
            rd_q <= rd_nx;
         end
         cnt_q <= cnt_q + {4'd0, do_push} - {4'd0, do_pop};
      end
   end
endmodule

// [hw/pci_scsi_bus_master_dma.v]
// Bus-master DMA engine between the host register/memory port and the SCSI block
// Functional notes
// (RULE1) All DMA bytes pass a 96-byte FIFO of 24 doublewords.
// (RULE2) Register PIO to SCSI bypasses FIFO, one byte on the low lane.
// (RULE3) Address bit 4 low routes to SCSI registers, high to DMA registers; the code also routes any address with bit 6 high to DMA registers.
// (RULE4) SCSI side moves two bytes per request/acknowledge handshake.
// (RULE5) Memory writes burst once 16 doublewords are held.
// (RULE6) Residue below threshold is still delivered in shorter bursts.
// (RULE7) Memory reads burst into the FIFO, then feed the SCSI side.
// (RULE8) Funnel packs and unpacks 32-bit words to 16-bit halves.
// (RULE9) Bursts never cross a 4 KByte page.
// (RULE10) Command code 01 flushes remaining FIFO data to memory.
// (RULE11) Flush completion sets status bit 5; no interrupt.
// (RULE12) Software checks SCSI interrupt, waits SCSI FIFO empty, flushes, idles.
// (RULE13) Software fetches an odd residual byte by PIO; no flush on reads.
// (RULE14) Software idles, programs SCSI then DMA, starts, idles afterwards.
// (RULE15) Software builds the descriptor list before the normal sequence.
// (RULE16) Software writes command twice: idle code with bits 7:4, then start.
// (RULE17) Bits 7 and 4 stay unchanged from idle write through the run.
// (RULE18) Interrupt enables 6:5 are captured when start is written.
// (RULE19) Only the low command byte is used; upper bytes read zero.
// (RULE20) Codes: 00 idle, 01 flush, 10 abort, 11 start.
// (RULE21) Bit 7 high writes memory, low reads memory; reset clears it.
// (RULE22) Stall SCSI side while FIFO full, memory writes while empty.
`timescale 1ns/1ps
`include "dma_defs.vh"
module pci_scsi_bus_master_dma (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // Register access
   input  wire [7:0]  reg_addr_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [31:0] reg_wdata_in,
   output reg  [31:0] reg_rdata_out,
   output reg         reg_rvalid_out,
   // SCSI block register port
   output reg         scsi_cs_out,
   output reg         scsi_rd_out,
   output reg         scsi_wr_out,
   output reg  [4:0]  scsi_addr_out,
   output reg  [7:0]  scsi_wdata_out,
   input  wire [7:0]  scsi_rdata_in,
   input  wire        scsi_irq_in,
   // SCSI block DMA port
   input  wire        transfer_request_in,
   output reg         transfer_acknowledge_out,
   input  wire [15:0] scsi_din_in,
   output reg  [15:0] scsi_dout_out,
   // Memory master port
   output reg         mem_req_out,
   output reg         mem_write_out,
   output reg  [31:0] mem_addr_out,
   output reg  [3:0]  mem_be_out,
   output reg  [31:0] mem_wdata_out,
   input  wire        mem_ack_in,
   input  wire [31:0] mem_rdata_in
);
   localparam S_IDLE  = 2'd0;
   localparam S_RUN   = 2'd1;
   localparam S_BURST = 2'd2;
   localparam S_DONE  = 2'd3;
   function hit;
      input [7:0] a;
      input [7:0] off;
      hit = (a[7:2] == off[7:2]);
   endfunction
   function [3:0] be_of;
      input [23:0] n;
      begin
         if (n >= 24'd4) be_of = 4'hf;
         else if (n == 24'd3) be_of = 4'h7;
         else if (n == 24'd2) be_of = 4'h3;
         else if (n == 24'd1) be_of = 4'h1;
         else be_of = 4'h0;
      end
   endfunction
   reg  [1:0]  state_q;
   reg  [7:0]  cmd_q;
   reg  [23:0] stc_q;
   reg  [31:0] spa_q;
   reg  [23:0] wbc_q;
   reg  [31:0] wac_q;
   reg  [31:0] dlb_q;
   reg  [31:0] wdc_q;
   reg  [1:0]  irq_en_q;
   reg         st_abort_q;
   reg         st_done_q;
   reg         st_flush_q;
   reg  [23:0] left_q;
   reg  [15:0] half_q;
   reg         half_v_q;
   reg         sel_q;
   reg         drain_q;
   reg  [4:0]  burst_q;
   reg         pend_q;
   reg         pend_dma_q;
   reg  [7:0]  pend_addr_q;
   wire [31:0] head;
   wire [31:0] next;
   wire [4:0]  cnt;
   wire        full;
   wire        empty;
   reg         push;
   reg  [31:0] push_data;
   reg         pop;
   reg  [4:0]  len;
   wire        dma_sel  = reg_addr_in[6] | reg_addr_in[`ROUTE_BIT];  // RULE3
   wire        dwr      = reg_wr_in & dma_sel;
   wire        cmd_wr   = dwr & hit(reg_addr_in, `OFF_CMD);
   wire [1:0]  code     = reg_wdata_in[1:0];
   wire        idle_ish = (state_q == S_IDLE) | (state_q == S_DONE);
   wire        start    = cmd_wr & (code == `CODE_START) & idle_ish;
   wire        abort    = cmd_wr & (code == `CODE_ABORT) & ~idle_ish;  // RULE20
   wire        flush    = cmd_wr & (code == `CODE_FLUSH) & cmd_q[`CMD_DIR] & ~idle_ish;
   wire        running  = (state_q == S_RUN) | (state_q == S_BURST);
   wire        wmode    = cmd_q[`CMD_DIR];  // RULE21
   wire        ack      = transfer_acknowledge_out;
   wire        take     = running & wmode & transfer_request_in & ~ack &
                          (left_q != 24'd0) & ~full;  // RULE4 RULE22
   wire        give     = running & ~wmode & transfer_request_in & ~ack &
                          (left_q != 24'd0) & ~empty;  // RULE7
   wire        drain_push = drain_q & half_v_q & ~ack & ~full;
   wire        beat     = (state_q == S_BURST) & mem_ack_in;
   wire [23:0] dec      = (wbc_q >= 24'd4) ? 24'd4 : wbc_q;
   wire [23:0] wbc_nx   = beat ? wbc_q - dec : wbc_q;
   wire [31:0] wac_nx   = beat ? wac_q + 32'd4 : wac_q;
   wire [23:0] lstep    = (left_q >= 24'd2) ? 24'd2 : left_q;
   wire [10:0] page_left = `PAGE_WORDS - {1'b0, wac_q[11:2]};
   wire [21:0] need     = wbc_q[23:2] + {21'd0, |wbc_q[1:0]};
   wire [4:0]  room     = `FIFO_WORDS - cnt;
   wire        go_w     = wmode & ((cnt >= `BURST_WORDS) |
                          ((cnt != 5'd0) & (drain_q | ((left_q == 24'd0) & ~half_v_q))));
   wire        go_r     = ~wmode & (wbc_q != 24'd0) &
                          ((room >= `BURST_WORDS) | ({17'd0, room} >= need));
   wire        w_end    = wmode & empty & ~half_v_q & ~ack &
                          ((wbc_q == 24'd0) | drain_q);
   wire        r_end    = ~wmode & (left_q == 24'd0) & ~ack;
   wire        st_rd    = pend_q & pend_dma_q & hit(pend_addr_q, `OFF_STATUS);
   // Burst length: FIFO contents or room, remaining words, page end
   always @* begin
      len = `BURST_WORDS;
      if (wmode && cnt < len) len = cnt;  // RULE6
      if (!wmode && need < {17'd0, len}) len = need[4:0];
      if (page_left < {6'd0, len}) len = page_left[4:0];  // RULE9
   end
   // Funnel: halves pack into words toward memory, words split toward SCSI
   always @* begin
      push      = 1'b0;
      push_data = mem_rdata_in;
      pop       = 1'b0;
      if (wmode) begin
         if (ack && (half_v_q || left_q <= 24'd2)) begin
            push      = 1'b1;  // RULE8
            push_data = half_v_q ? {scsi_din_in, half_q} : {16'h0000, scsi_din_in};
         end else if (drain_push) begin
            push      = 1'b1;
            push_data = {16'h0000, half_q};
         end
         pop = beat;  // RULE22
      end else begin
         push = beat;  // RULE7
         pop  = give & (sel_q | left_q <= 24'd2);
      end
   end
   dma_word_fifo fifo (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .clear_in     (start | abort),
      .push_in      (push),
      .push_data_in (push_data),
      .pop_in       (pop),
      .head_out     (head),
      .next_out     (next),
      .count_out    (cnt),
      .full_out     (full),
      .empty_out    (empty)
   );  // RULE1
   // Control, counters and the two data sides
   always @(posedge clk_in) begin
      if (rst_in) begin
         state_q    <= S_IDLE;
         cmd_q      <= `CMD_RESET;
         stc_q      <= 24'h000000;
         spa_q      <= 32'h00000000;
         wbc_q      <= `WBC_RESET;
         wac_q      <= `WAC_RESET;
         dlb_q      <= 32'h00000000;
         wdc_q      <= 32'h00000000;
         irq_en_q   <= 2'b00;
         st_abort_q <= 1'b0;
         st_done_q  <= 1'b0;
         st_flush_q <= 1'b0;
         left_q     <= 24'h000000;
         half_q     <= 16'h0000;
         half_v_q   <= 1'b0;
         sel_q      <= 1'b0;
         drain_q    <= 1'b0;
         burst_q    <= 5'd0;
         transfer_acknowledge_out <= 1'b0;
         scsi_dout_out <= 16'h0000;
         mem_req_out   <= 1'b0;
         mem_write_out <= 1'b0;
         mem_addr_out  <= 32'h00000000;
         mem_be_out    <= 4'h0;
         mem_wdata_out <= 32'h00000000;
      end else begin
         if (cmd_wr) cmd_q <= {reg_wdata_in[7:4], 2'b00, code};  // RULE19
         if (dwr && hit(reg_addr_in, `OFF_STC)) stc_q <= reg_wdata_in[23:0];
         if (dwr && hit(reg_addr_in, `OFF_SPA)) spa_q <= reg_wdata_in;
         if (dwr && hit(reg_addr_in, `OFF_DLB)) dlb_q <= reg_wdata_in;
         // Status clears on read, but an event in the same cycle wins
         st_abort_q <= abort | (st_abort_q & ~st_rd & ~start);
         st_done_q  <= (running & ~drain_q & (w_end | r_end)) |
                       (st_done_q & ~st_rd & ~start);
         st_flush_q <= (running & drain_q & w_end) | (st_flush_q & ~st_rd & ~start);  // RULE11
         transfer_acknowledge_out <= take | give;  // RULE4
         mem_addr_out  <= wac_nx;
         mem_be_out    <= be_of(wbc_nx);
         mem_wdata_out <= pop ? next : head;
         if (wmode && ack) begin
            left_q <= left_q - lstep;
            if (!half_v_q && left_q > 24'd2) begin
               half_q   <= scsi_din_in;
               half_v_q <= 1'b1;
            end else begin
               half_v_q <= 1'b0;
            end
         end else if (drain_push) begin
            half_v_q <= 1'b0;
         end
         if (give) begin
            scsi_dout_out <= sel_q ? head[31:16] : head[15:0];  // RULE8
            left_q        <= left_q - lstep;
            sel_q         <= ~pop;
         end
         if (flush) drain_q <= 1'b1;  // RULE10
         if (beat) begin
            wbc_q   <= wbc_nx;
            wac_q   <= wac_nx;
            burst_q <= burst_q - 5'd1;
         end
         case (state_q)
            S_IDLE, S_DONE: begin
               if (start) begin
                  wbc_q         <= stc_q;
                  wac_q         <= (spa_q + 32'd3) & 32'hfffffffc;
                  wdc_q         <= dlb_q;
                  left_q        <= stc_q;
                  irq_en_q      <= reg_wdata_in[6:5];  // RULE18
                  mem_write_out <= reg_wdata_in[`CMD_DIR];
                  half_v_q      <= 1'b0;
                  sel_q         <= 1'b0;
                  drain_q       <= 1'b0;
                  state_q       <= S_RUN;
               end else if (cmd_wr && code == `CODE_IDLE) begin
                  state_q <= S_IDLE;
               end
            end
            S_RUN: begin
               if (abort) begin
                  state_q <= S_IDLE;
                  transfer_acknowledge_out <= 1'b0;
               end else if (w_end || r_end) begin
                  drain_q <= 1'b0;
                  state_q <= S_DONE;
               end else if ((go_w || go_r) && len != 5'd0) begin
                  burst_q     <= len;  // RULE5 RULE6
                  mem_req_out <= 1'b1;
                  state_q     <= S_BURST;
               end
            end
            default: begin
               if (abort) begin
                  mem_req_out <= 1'b0;
                  transfer_acknowledge_out <= 1'b0;
                  state_q     <= S_IDLE;
               end else if (beat && burst_q == 5'd1) begin
                  mem_req_out <= 1'b0;
                  state_q     <= S_RUN;
               end
            end
         endcase
      end
   end
   // Register reads: one stage to the SCSI block, one to the answer
   always @(posedge clk_in) begin
      if (rst_in) begin
         pend_q         <= 1'b0;
         pend_dma_q     <= 1'b0;
         pend_addr_q    <= 8'h00;
         reg_rdata_out  <= 32'h00000000;
         reg_rvalid_out <= 1'b0;
         scsi_cs_out    <= 1'b0;
         scsi_rd_out    <= 1'b0;
         scsi_wr_out    <= 1'b0;
         scsi_addr_out  <= 5'd0;
         scsi_wdata_out <= 8'h00;
      end else begin
         pend_q         <= reg_rd_in;
         pend_dma_q     <= dma_sel;
         pend_addr_q    <= reg_addr_in;
         scsi_cs_out    <= (reg_rd_in | reg_wr_in) & ~dma_sel;  // RULE2 RULE3
         scsi_rd_out    <= reg_rd_in & ~dma_sel;
         scsi_wr_out    <= reg_wr_in & ~dma_sel;
         scsi_addr_out  <= reg_addr_in[4:0];
         scsi_wdata_out <= reg_wdata_in[7:0];
         reg_rvalid_out <= pend_q;
         if (!pend_q) begin
            reg_rdata_out <= 32'h00000000;
         end else if (!pend_dma_q) begin
            reg_rdata_out <= {24'h000000, scsi_rdata_in};  // RULE2
         end else if (hit(pend_addr_q, `OFF_CMD)) begin
            reg_rdata_out <= {24'h000000, cmd_q};  // RULE19
         end else if (hit(pend_addr_q, `OFF_STC)) begin
            reg_rdata_out <= {8'h00, stc_q};
         end else if (hit(pend_addr_q, `OFF_SPA)) begin
            reg_rdata_out <= spa_q;
         end else if (hit(pend_addr_q, `OFF_WBC)) begin
            reg_rdata_out <= {8'h00, wbc_q};
         end else if (hit(pend_addr_q, `OFF_WAC)) begin
            reg_rdata_out <= wac_q;
         end else if (hit(pend_addr_q, `OFF_STATUS)) begin
            reg_rdata_out <= {24'h000000, irq_en_q, st_flush_q, scsi_irq_in,
                              st_done_q, st_abort_q, 1'b0, running};
         end else if (hit(pend_addr_q, `OFF_DLB)) begin
            reg_rdata_out <= dlb_q;
         end else if (hit(pend_addr_q, `OFF_WDC)) begin
            reg_rdata_out <= wdc_q;
         end else begin
            reg_rdata_out <= 32'h00000000;
         end
      end
   end
endmodule

// [test/dma_properties.sv]
// Concurrent checks on the DMA engine's register, SCSI and memory ports
`timescale 1ns/1ps
module dma_properties (
   // Clock and reset
   input logic        clk_in,
   input logic        rst_in,
   // Register access
   input logic [7:0]  reg_addr_in,
   input logic        reg_wr_in,
   input logic        reg_rd_in,
   input logic [31:0] reg_wdata_in,
   input logic [31:0] reg_rdata_out,
   input logic        reg_rvalid_out,
   // SCSI block
   input logic        scsi_cs_out,
   input logic        scsi_rd_out,
   input logic        scsi_wr_out,
   input logic [4:0]  scsi_addr_out,
   input logic [7:0]  scsi_wdata_out,
   input logic [7:0]  scsi_rdata_in,
   input logic        transfer_request_in,
   input logic        transfer_acknowledge_out,
   // Memory
   input logic        mem_req_out,
   input logic [31:0] mem_addr_out,
   input logic        mem_ack_in
);
   logic [5:0] beats_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Words taken so far in the running burst
   always @(posedge clk_in) begin
      beats_q <= (rst_in || !mem_req_out) ? 6'd0 : beats_q + {5'd0, mem_ack_in};
   end
   pio_route_a: assert property (
      reg_rd_in && !reg_addr_in[6] && !reg_addr_in[4]
      |=> scsi_cs_out && scsi_rd_out && scsi_addr_out == $past(reg_addr_in[4:0]))
      else $error("SCSI register read not routed");
   dma_route_a: assert property (
      (reg_rd_in || reg_wr_in) && reg_addr_in[4] |=> !scsi_cs_out)
      else $error("DMA register access reached SCSI block");
   pio_lane_a: assert property (
      scsi_rd_out |=> reg_rvalid_out && reg_rdata_out == {24'h000000, $past(scsi_rdata_in)})
      else $error("PIO byte not on low lane");
   pio_write_a: assert property (
      reg_wr_in && !reg_addr_in[6] && !reg_addr_in[4]
      |=> scsi_wr_out && scsi_wdata_out == $past(reg_wdata_in[7:0]))
      else $error("PIO write byte lost");
   ack_spacing_a: assert property (
      transfer_acknowledge_out |=> !transfer_acknowledge_out)
      else $error("Acknowledge two cycles in a row");
   ack_cause_a: assert property (
      $rose(transfer_acknowledge_out) |-> $past(transfer_request_in))
      else $error("Acknowledge without request");
   page_end_a: assert property (
      mem_req_out && mem_ack_in && mem_addr_out[11:2] == 10'h3ff |=> !mem_req_out)
      else $error("Burst crossed a page");
   burst_limit_a: assert property (
      mem_req_out |-> beats_q <= 6'd15)
      else $error("Burst longer than sixteen words");
   burst_hold_a: assert property (
      mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
      else $error("Burst word dropped while stalled");
   cmd_reserved_a: assert property (
      reg_rd_in && reg_addr_in == 8'h40 |-> ##2 reg_rvalid_out && reg_rdata_out[31:8] == 24'h0)
      else $error("Command upper bytes not zero");
endmodule
bind pci_scsi_bus_master_dma dma_properties u_props (
   .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .scsi_cs_out(scsi_cs_out), .scsi_rd_out(scsi_rd_out),
   .scsi_wr_out(scsi_wr_out), .scsi_addr_out(scsi_addr_out), .scsi_wdata_out(scsi_wdata_out),
   .scsi_rdata_in(scsi_rdata_in), .transfer_request_in(transfer_request_in),
   .transfer_acknowledge_out(transfer_acknowledge_out), .mem_req_out(mem_req_out),
   .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in));

// [test/far_side_model.sv]
// Behavioural SCSI block and host memory on the far side of the engine
`timescale 1ns/1ps
module far_side_model (
   // Clock and bench control
   input  wire        clk_in,
   input  wire        load_in,
   input  wire [7:0]  count_in,
   input  wire        slow_in,
   // SCSI block
   input  wire [4:0]  scsi_addr_in,
   output wire [7:0]  scsi_rdata_out,
   input  wire        ack_in,
   input  wire [15:0] dout_in,
   output wire        request_out,
   output wire [15:0] din_out,
   // Memory
   input  wire        req_in,
   input  wire        write_in,
   input  wire [31:0] addr_in,
   input  wire [31:0] wdata_in,
   output wire        mem_ack_out,
   output wire [31:0] mem_rdata_out
);
   logic [31:0] mem [0:8191];
   logic [15:0] rx [0:63];
   logic [7:0]  left_q = 8'h00;
   logic [7:0]  idx_q = 8'h00;
   logic [7:0]  first_at = 8'h00;
   logic        go_q = 1'b0;
   logic        seen_q = 1'b0;
   // Register window echoes its offset so misrouting shows
   assign scsi_rdata_out = {3'b101, scsi_addr_in};
   // Slow mode drops the request every other cycle
   assign request_out = (left_q != 8'h00) && (go_q || !slow_in);
   // Junk outside the acknowledge cycle
   assign din_out = ack_in ? {idx_q ^ 8'h5a, idx_q} : ~{idx_q ^ 8'h5a, idx_q};
   assign mem_ack_out = req_in && (go_q || !slow_in);
   assign mem_rdata_out = mem_ack_out ? mem[addr_in[14:2]] : ~addr_in;
   always @(posedge clk_in) begin
      go_q <= ~go_q;
      if (load_in) begin
         left_q <= count_in;
         idx_q <= 8'h00;
         seen_q <= 1'b0;
      end else if (ack_in) begin
         rx[idx_q[5:0]] <= dout_in;
         left_q <= left_q - 8'h01;
         idx_q <= idx_q + 8'h01;
      end
      if (req_in && !seen_q && !load_in) begin
         seen_q <= 1'b1;
         first_at <= idx_q;
      end
      if (mem_ack_out && write_in) begin
         mem[addr_in[14:2]] <= wdata_in;
      end
   end
endmodule

// [test/testbench.sv]
// Self-checking bench for the bus-master DMA engine
`timescale 1ns/1ps
module testbench;
   logic clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, scsi_irq_in = 0;
   logic load_in = 0, slow_in = 0;
   logic [7:0] reg_addr_in = 8'h00, count_in = 8'h00, scsi_rdata_in, scsi_wdata_out;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
   logic reg_rvalid_out, scsi_cs_out, scsi_rd_out, scsi_wr_out, transfer_request_in;
   logic transfer_acknowledge_out, mem_req_out, mem_write_out, mem_ack_in;
   logic [4:0] scsi_addr_out;
   logic [15:0] scsi_din_in, scsi_dout_out;
   logic [3:0] mem_be_out;
   integer fail_count = 0, num_checks = 0;
   pci_scsi_bus_master_dma dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .scsi_cs_out(scsi_cs_out), .scsi_rd_out(scsi_rd_out), .scsi_wr_out(scsi_wr_out),
      .scsi_addr_out(scsi_addr_out), .scsi_wdata_out(scsi_wdata_out),
      .scsi_rdata_in(scsi_rdata_in), .scsi_irq_in(scsi_irq_in),
      .transfer_request_in(transfer_request_in),
      .transfer_acknowledge_out(transfer_acknowledge_out), .scsi_din_in(scsi_din_in),
      .scsi_dout_out(scsi_dout_out), .mem_req_out(mem_req_out), .mem_write_out(mem_write_out),
      .mem_addr_out(mem_addr_out), .mem_be_out(mem_be_out), .mem_wdata_out(mem_wdata_out),
      .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
   far_side_model far (.clk_in(clk_in), .load_in(load_in), .count_in(count_in),
      .slow_in(slow_in), .scsi_addr_in(scsi_addr_out), .scsi_rdata_out(scsi_rdata_in),
      .ack_in(transfer_acknowledge_out), .dout_in(scsi_dout_out),
      .request_out(transfer_request_in), .din_out(scsi_din_in), .req_in(mem_req_out),
      .write_in(mem_write_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   function automatic logic [31:0] word(input integer i);
      logic [7:0] a, b;
      a = 8'(2 * i);
      b = 8'(2 * i + 1);
      return {b ^ 8'h5a, b, a ^ 8'h5a, a};
   endfunction
   task give_verdict;
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      logic got;
      got = 0;
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      for (int n = 0; n < 4 && !got; n++) begin
         @(posedge clk_in);
         got = (reg_rvalid_out === 1'b1);
         d = reg_rdata_out;
      end
      if (!got) begin
         fail_count++;
         give_verdict;
      end
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask
   // Status reads clear the event bits, so the hit is returned
   task poll(input integer b, output logic [31:0] st);
      st = 32'h0;
      for (int n = 0; n < 300 && st[b] !== 1'b1; n++) rd(8'h54, st);
      if (st[b] !== 1'b1) begin
         fail_count++;
         give_verdict;
      end
   endtask
   task load(input logic [7:0] n);
      @(posedge clk_in);
      load_in <= 1'b1;
      count_in <= n;
      @(posedge clk_in);
      load_in <= 1'b0;
   endtask
   initial begin
      logic [31:0] v;
      integer i;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      rc(8'h40, 32'h0);
      rc(8'h4c, 32'h0);
      rc(8'h50, 32'hffffffff);
      rc(8'h54, 32'h0);
      wr(8'h44, 32'h00abcdef);
      rc(8'h44, 32'h00abcdef);
      wr(8'h58, 32'h12345678);
      rc(8'h58, 32'h12345678);
      wr(8'h4c, 32'h00001234);
      rc(8'h4c, 32'h0);
      wr(8'h40, 32'hffffff90);
      rc(8'h40, 32'h90);
      rc(8'h10, 32'h0);
      rc(8'h60, 32'h0);
      rc(8'h0c, {24'h0, 3'b101, 5'h0c});
      wr(8'h08, 32'hffffff5a);
      // Write to memory, starting four words short of a page end
      wr(8'h44, 32'd72);
      wr(8'h48, 32'h00000ff0);
      wr(8'h40, 32'h80);
      load(8'd36);
      wr(8'h40, 32'h83);
      poll(3, v);
      chk(v[2:0], 3'b000);
      rc(8'h4c, 32'h0);
      chk(mem_be_out, 4'h0);
      rc(8'h50, 32'h1038);
      chk(far.first_at >= 8'd32, 1'b1);
      for (i = 0; i < 18; i++) chk(far.mem[10'h3fc + i], word(i));
      wr(8'h40, 32'h80);
      // Disconnect with five words parked, then flush them out
      scsi_irq_in <= 1'b1;
      wr(8'h44, 32'd40);
      wr(8'h48, 32'h00003000);
      wr(8'h40, 32'he0);
      load(8'd10);
      wr(8'h40, 32'he3);
      for (i = 0; i < 300 && far.left_q != 8'h00; i++) @(posedge clk_in);
      repeat (10) @(posedge clk_in);
      chk(far.left_q, 8'h00);
      wr(8'h40, 32'h83);
      rd(8'h54, v);
      chk({v[7:4], v[0]}, 5'b11011);
      wr(8'h40, 32'h81);
      poll(5, v);
      chk(v[5:3], 3'b110);
      rc(8'h4c, 32'd20);
      chk(mem_be_out, 4'hf);
      rc(8'h08, {24'h0, 3'b101, 5'h08});
      for (i = 0; i < 5; i++) chk(far.mem[12'hc00 + i], word(i));
      wr(8'h40, 32'h80);
      scsi_irq_in <= 1'b0;
      // Read from memory with both far ends stalling
      for (i = 0; i < 16; i++) far.mem[12'h800 + i] = word(20 + i);
      slow_in <= 1'b1;
      wr(8'h44, 32'd16);
      wr(8'h48, 32'h00002000);
      wr(8'h40, 32'h00);
      load(8'd8);
      wr(8'h40, 32'h03);
      poll(3, v);
      for (i = 0; i < 8; i++) begin
         v = word(20 + i / 2);
         chk(far.rx[i], i % 2 ? v[31:16] : v[15:0]);
      end
      // Abort a read that the SCSI side never drains
      slow_in <= 1'b0;
      wr(8'h44, 32'd64);
      wr(8'h40, 32'h03);
      repeat (40) @(posedge clk_in);
      wr(8'h40, 32'h02);
      poll(2, v);
      chk(v[3], 1'b0);
      wr(8'h40, 32'h00);
      give_verdict;
   end
endmodule
